// ===== hdl/amseq_consts.svh
// offsets, field positions, reset values and timing figures of the move sequencer
`ifndef AMSEQ_CONSTS_SVH
`define AMSEQ_CONSTS_SVH

// apb byte offsets
`define AMSEQ_OFS_CTRL      12'h000
`define AMSEQ_OFS_SEG       12'h004
`define AMSEQ_OFS_DWELL     12'h008
`define AMSEQ_OFS_CFG       12'h00C
`define AMSEQ_OFS_STATUS    12'h010

// command word bit positions
`define AMSEQ_CB_PROG       0
`define AMSEQ_CB_SEGVAL     1
`define AMSEQ_CB_PERSIST    2
`define AMSEQ_CB_ASM        3
`define AMSEQ_CB_BLEND      4
`define AMSEQ_CB_BLEND_CCW  5
`define AMSEQ_CB_EDGE       6
`define AMSEQ_CB_HOLD       7
`define AMSEQ_CB_IMM        8
`define AMSEQ_CB_ERRCLR     9
`define AMSEQ_CB_JOG_CW     10
`define AMSEQ_CB_JOG_CCW    11
`define AMSEQ_CTRL_W        12

// configuration word fields
`define AMSEQ_CFG_TRIG_LSB  0
`define AMSEQ_CFG_ESTOP_LSB 2
`define AMSEQ_CFG_W         5

// reset values
`define AMSEQ_CTRL_RST      12'h000
`define AMSEQ_SEG_RST       24'h000000
`define AMSEQ_DWELL_RST     16'h0000
`define AMSEQ_CFG_RST       5'h00

// profile size limits
`define AMSEQ_SEG_MIN       2
`define AMSEQ_SEG_MAX       16

// dwell time unit and clock period, both in ns
`define AMSEQ_DWELL_UNIT_NS 1000000
`define AMSEQ_CLK_PERIOD_NS 20

`endif

// ===== hdl/amseq_pkg.sv
// types shared by the move sequencer files
package amseq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LAUNCH = 3'b001,
    ST_RUN    = 3'b010,
    ST_DWELL  = 3'b011,
    ST_STOP   = 3'b100,
    ST_SAVE   = 3'b101,
    ST_LOCK   = 3'b110
  } amseq_state_t;

endpackage : amseq_pkg

// ===== hdl/amseq_segmem.sv
// segment store: flip-flop entries addressed by an index
module amseq_segmem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 24,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_idx,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // one register per entry, written when its index is selected
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          mem_r[gi] <= '0;
        end else if (wr_en && (wr_idx == AW'(gi))) begin
          mem_r[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // asynchronous read by index
  assign rd_data = mem_r[rd_idx];

endmodule : amseq_segmem

// ===== hdl/amseq_top.sv
// assembled move sequencer: segment loading, dwell runs, stops and triggered start
//
// The placing of the registers and register access over APB were chosen for this implementation.
`include "amseq_consts.svh"

// Overview of operation
// - stop after each dwell segment, wait the dwell time, then start the next
// - dwell segments: positive target runs clockwise, negative counter-clockwise
// - hold toggle during a run: decelerate to start speed, then end the move
// - rising immediate-stop bit stops motion at once, no ramp
// - rising edge on an input enabled as emergency stop stops motion at once
// - limit stops at once; same-direction limit blocks that direction until clear
// - one loading procedure; start bit picks type; blend ignores signs
// - program request sets programming-active and segment-request
// - on segment-valid check data, drop segment-request, flag bad data
// - host drops valid after request drops; device then requests again
// - handshake repeats per segment; at most sixteen segments stored
// - program request falling clears programming-active and segment-request
// - persist bit acts only on the falling edge of program request
// - after a save show green or red, then accept no more commands
// - edge-trigger command waits for a rising edge on the chosen input
// - trigger input falling does not stop the move
// - trigger ignored while running; reruns on each later edge while idle
// - new triggered parameters only after a fresh command rising edge
// - triggered jog stops under control when its command bit clears
// - hold, immediate stop and error clear ignore the edge-trigger bit
// - a profile holds between two and sixteen segments; a triggered start runs with fewer than two
module amseq_top
  import amseq_pkg::*;
#(
  parameter int SEG_W      = 24,
  parameter int DWELL_W    = 16,
  parameter int TICK_CYCLES = `AMSEQ_DWELL_UNIT_NS / `AMSEQ_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic      [31:0]        prdata,
  output logic                    pslverr,
  // physical inputs and limits
  input  wire logic [2:0]         phys_in,
  input  wire logic               limit_cw,
  input  wire logic               limit_ccw,
  // motion engine
  output logic                    mv_start,
  output logic      [SEG_W-2:0]   mv_dist,
  output logic                    mv_ccw,
  output logic                    mv_cont,
  output logic                    mv_decel,
  output logic                    mv_abort,
  input  wire logic               mv_done,
  // non-volatile store and indicator
  output logic                    nv_save,
  input  wire logic               nv_done,
  input  wire logic               nv_ok,
  output logic                    led_green,
  output logic                    led_red
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [4:0] SEG_MAX = 5'(`AMSEQ_SEG_MAX);
  localparam logic [4:0] SEG_MIN = 5'(`AMSEQ_SEG_MIN);

  amseq_state_t               st_r;
  logic [`AMSEQ_CTRL_W-1:0]   ctrl_r, ctrl_q_r;
  logic [SEG_W-1:0]           seg_r;
  logic [DWELL_W-1:0]         dwell_r, dwell_lat_r, dwell_cnt_r;
  logic [`AMSEQ_CFG_W-1:0]    cfg_r;
  logic [2:0]                 in_q_r;
  logic                       lcw_q_r, lccw_q_r;
  logic                       prog_act_r, seg_req_r, cmd_err_r, lock_cw_r, lock_ccw_r;
  logic                       armed_r, blend_r, bccw_r, jog_r, jccw_r;
  logic [4:0]                 wr_ptr_r, seg_idx_r;
  logic [TW-1:0]              tick_cnt_r;
  logic                       tick_r;
  logic [SEG_W-1:0]           rd_data;

  // command bit views and edges
  logic prog, seg_val, prog_rise, prog_fall, imm_rise, hold_tog, clr_rise;
  logic cmd_any, cmd_rise, trig_rise, estop_rise, lim_hit, busy, moving, locked;
  logic abort_go, go_now, seg_ok, last_seg, wr_fire, rd_fire, map_hit, dir_ccw;
  assign prog      = ctrl_r[`AMSEQ_CB_PROG];
  assign seg_val   = ctrl_r[`AMSEQ_CB_SEGVAL];
  assign prog_rise = prog & ~ctrl_q_r[`AMSEQ_CB_PROG];
  assign prog_fall = ~prog & ctrl_q_r[`AMSEQ_CB_PROG];
  assign imm_rise  = ctrl_r[`AMSEQ_CB_IMM] & ~ctrl_q_r[`AMSEQ_CB_IMM];
  assign hold_tog  = ctrl_r[`AMSEQ_CB_HOLD] ^ ctrl_q_r[`AMSEQ_CB_HOLD];
  assign clr_rise  = ctrl_r[`AMSEQ_CB_ERRCLR] & ~ctrl_q_r[`AMSEQ_CB_ERRCLR];
  assign cmd_any   = ctrl_r[`AMSEQ_CB_ASM] | ctrl_r[`AMSEQ_CB_JOG_CW]
                   | ctrl_r[`AMSEQ_CB_JOG_CCW];
  assign cmd_rise  = cmd_any & ~(ctrl_q_r[`AMSEQ_CB_ASM] | ctrl_q_r[`AMSEQ_CB_JOG_CW]
                   | ctrl_q_r[`AMSEQ_CB_JOG_CCW]);
  assign trig_rise = phys_in[cfg_r[`AMSEQ_CFG_TRIG_LSB +: 2]]
                   & ~in_q_r[cfg_r[`AMSEQ_CFG_TRIG_LSB +: 2]];
  assign estop_rise = |(phys_in & ~in_q_r & cfg_r[`AMSEQ_CFG_ESTOP_LSB +: 3]);
  assign locked    = (st_r == ST_LOCK) || (st_r == ST_SAVE);
  assign busy      = (st_r == ST_LAUNCH) || (st_r == ST_RUN) || (st_r == ST_DWELL)
                   || (st_r == ST_STOP);
  assign moving    = (st_r == ST_RUN) || (st_r == ST_STOP);
  assign lim_hit   = moving & ((limit_cw & ~lcw_q_r) | (limit_ccw & ~lccw_q_r));
  assign abort_go  = busy & (imm_rise | estop_rise | lim_hit);
  // immediate start on a plain rising command, or armed start on a trigger edge
  assign go_now    = (st_r == ST_IDLE) && !prog_act_r
                   && ((cmd_rise && !ctrl_r[`AMSEQ_CB_EDGE])
                       || (armed_r && cmd_any && trig_rise));
  assign seg_ok    = (seg_r != '0) && (wr_ptr_r < SEG_MAX);
  assign last_seg  = (seg_idx_r + 5'h01) >= wr_ptr_r;
  // direction of the segment in launch: latched jog or blend direction, else the stored segment's sign bit
  assign dir_ccw   = jog_r ? jccw_r : (blend_r ? bccw_r : rd_data[SEG_W-1]);
  assign map_hit   = (paddr == `AMSEQ_OFS_CTRL) || (paddr == `AMSEQ_OFS_SEG)
                   || (paddr == `AMSEQ_OFS_DWELL) || (paddr == `AMSEQ_OFS_CFG)
                   || (paddr == `AMSEQ_OFS_STATUS);
  assign wr_fire   = psel & penable & pready & pwrite & map_hit;
  assign rd_fire   = psel & penable & ~pready;

  // apb answer: one wait state, data and error registered
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_fire;
      pslverr <= rd_fire & ~map_hit;
      prdata  <= 32'h00000000;
      if (rd_fire && !pwrite) begin
        unique case (paddr)
          `AMSEQ_OFS_CTRL:   prdata <= 32'(ctrl_r);
          `AMSEQ_OFS_SEG:    prdata <= 32'(seg_r);
          `AMSEQ_OFS_DWELL:  prdata <= 32'(dwell_r);
          `AMSEQ_OFS_CFG:    prdata <= 32'(cfg_r);
          `AMSEQ_OFS_STATUS: prdata <= {11'h000, wr_ptr_r, 6'h00, locked, led_red,
                                        led_green, armed_r, busy, lock_ccw_r,
                                        lock_cw_r, cmd_err_r, seg_req_r, prog_act_r};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // software-written words; the command word freezes once saved
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r  <= `AMSEQ_CTRL_RST;
      seg_r   <= `AMSEQ_SEG_RST;
      dwell_r <= `AMSEQ_DWELL_RST;
      cfg_r   <= `AMSEQ_CFG_RST;
    end else if (wr_fire) begin
      if (paddr == `AMSEQ_OFS_CTRL && !locked) ctrl_r <= pwdata[`AMSEQ_CTRL_W-1:0];
      if (paddr == `AMSEQ_OFS_SEG)   seg_r   <= pwdata[SEG_W-1:0];
      if (paddr == `AMSEQ_OFS_DWELL) dwell_r <= pwdata[DWELL_W-1:0];
      if (paddr == `AMSEQ_OFS_CFG)   cfg_r   <= pwdata[`AMSEQ_CFG_W-1:0];
    end
  end

  // previous samples for edge detection
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q_r <= `AMSEQ_CTRL_RST;
      in_q_r   <= 3'h0;
      lcw_q_r  <= 1'b0;
      lccw_q_r <= 1'b0;
    end else begin
      ctrl_q_r <= ctrl_r;
      in_q_r   <= phys_in;
      lcw_q_r  <= limit_cw;
      lccw_q_r <= limit_ccw;
    end
  end

  // dwell time base: one pulse per dwell unit
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == TW'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // segment loading handshake
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_act_r <= 1'b0;
      seg_req_r  <= 1'b0;
      wr_ptr_r   <= 5'h00;
    end else if (prog_fall) begin
      prog_act_r <= 1'b0;
      seg_req_r  <= 1'b0;
    end else if (prog_rise && st_r == ST_IDLE) begin
      prog_act_r <= 1'b1;
      seg_req_r  <= 1'b1;
      wr_ptr_r   <= 5'h00;
    end else if (prog_act_r && seg_req_r && seg_val) begin
      seg_req_r <= 1'b0;
      if (seg_ok) wr_ptr_r <= wr_ptr_r + 5'h01;
    end else if (prog_act_r && !seg_req_r && !seg_val) begin
      seg_req_r <= 1'b1;
    end
  end

  // command error and direction locks; a set wins over a clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_err_r  <= 1'b0;
      lock_cw_r  <= 1'b0;
      lock_ccw_r <= 1'b0;
    end else begin
      if (prog_act_r && seg_req_r && seg_val && !seg_ok && !prog_fall)
        cmd_err_r <= 1'b1;
      else if (go_now && ctrl_r[`AMSEQ_CB_ASM] && wr_ptr_r < SEG_MIN && !armed_r)
        cmd_err_r <= 1'b1;
      else if (st_r == ST_LAUNCH && (dir_ccw ? lock_ccw_r : lock_cw_r))
        cmd_err_r <= 1'b1;
      else if (clr_rise)
        cmd_err_r <= 1'b0;
      if (lim_hit && limit_cw && !lcw_q_r && !mv_ccw)
        lock_cw_r <= 1'b1;
      else if (clr_rise)
        lock_cw_r <= 1'b0;
      if (lim_hit && limit_ccw && !lccw_q_r && mv_ccw)
        lock_ccw_r <= 1'b1;
      else if (clr_rise)
        lock_ccw_r <= 1'b0;
    end
  end

  // arming and latching of move parameters on a fresh command edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_r     <= 1'b0;
      blend_r     <= 1'b0;
      bccw_r      <= 1'b0;
      jog_r       <= 1'b0;
      jccw_r      <= 1'b0;
      dwell_lat_r <= '0;
    end else begin
      if (cmd_rise && st_r == ST_IDLE && !prog_act_r) begin
        armed_r     <= ctrl_r[`AMSEQ_CB_EDGE];
        blend_r     <= ctrl_r[`AMSEQ_CB_BLEND];
        bccw_r      <= ctrl_r[`AMSEQ_CB_BLEND_CCW];
        jog_r       <= ~ctrl_r[`AMSEQ_CB_ASM];
        jccw_r      <= ctrl_r[`AMSEQ_CB_JOG_CCW];
        dwell_lat_r <= dwell_r;
      end else if (!cmd_any) begin
        armed_r <= 1'b0;
      end
    end
  end

  // sequencer state machine and motion engine strobes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r        <= ST_IDLE;
      seg_idx_r   <= 5'h00;
      dwell_cnt_r <= '0;
      mv_start    <= 1'b0;
      mv_dist     <= '0;
      mv_ccw      <= 1'b0;
      mv_cont     <= 1'b0;
      mv_decel    <= 1'b0;
      mv_abort    <= 1'b0;
      nv_save     <= 1'b0;
      led_green   <= 1'b0;
      led_red     <= 1'b0;
    end else begin
      mv_start <= 1'b0;
      mv_decel <= 1'b0;
      mv_abort <= 1'b0;
      nv_save  <= 1'b0;
      if (abort_go) begin
        mv_abort <= 1'b1;
        st_r     <= ST_IDLE;
      end else begin
        unique case (st_r)
          ST_IDLE: begin
            if (prog_fall && ctrl_q_r[`AMSEQ_CB_PERSIST]) begin
              nv_save <= 1'b1;
              st_r    <= ST_SAVE;
            end else if (go_now && (!ctrl_r[`AMSEQ_CB_ASM] || armed_r
                                    || wr_ptr_r >= SEG_MIN)) begin
              seg_idx_r <= 5'h00;
              st_r      <= ST_LAUNCH;
            end
          end
          ST_LAUNCH: begin
            if (dir_ccw ? lock_ccw_r : lock_cw_r) begin
              st_r <= ST_IDLE;
            end else begin
              mv_start <= 1'b1;
              st_r     <= ST_RUN;
            end
          end
          ST_RUN: begin
            if (hold_tog || (jog_r && !cmd_any)) begin
              mv_decel <= 1'b1;
              st_r     <= ST_STOP;
            end else if (mv_done) begin
              if (jog_r || last_seg) begin
                st_r <= ST_IDLE;
              end else begin
                seg_idx_r   <= seg_idx_r + 5'h01;
                dwell_cnt_r <= dwell_lat_r;
                st_r        <= blend_r ? ST_LAUNCH : ST_DWELL;
              end
            end
          end
          ST_DWELL: begin
            if (hold_tog) begin
              st_r <= ST_IDLE;
            end else if (dwell_cnt_r == '0) begin
              st_r <= ST_LAUNCH;
            end else if (tick_r) begin
              dwell_cnt_r <= dwell_cnt_r - 1'b1;
            end
          end
          ST_STOP: begin
            if (mv_done) st_r <= ST_IDLE;
          end
          ST_SAVE: begin
            if (nv_done) begin
              led_green <= nv_ok;
              led_red   <= ~nv_ok;
              st_r      <= ST_LOCK;
            end
          end
          ST_LOCK: st_r <= ST_LOCK;
          default: st_r <= ST_IDLE;
        endcase
      end
      // direction and distance taken with the start strobe, stable while running
      if (st_r == ST_LAUNCH) begin
        mv_cont <= jog_r;
        mv_dist <= jog_r ? '0 : (rd_data[SEG_W-1] ? (SEG_W-1)'(-rd_data)
                                                   : rd_data[SEG_W-2:0]);
        mv_ccw  <= dir_ccw;
      end
    end
  end

  amseq_segmem #(
    .DEPTH (`AMSEQ_SEG_MAX),
    .WIDTH (SEG_W),
    .AW    (4)
  ) u_mem (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wr_en   (prog_act_r && seg_req_r && seg_val && seg_ok && !prog_fall),
    .wr_idx  (wr_ptr_r[3:0]),
    .wr_data (seg_r),
    .rd_idx  (seg_idx_r[3:0]),
    .rd_data (rd_data)
  );

  // checks of the documented behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_prog_sets_req: assert property (prog_rise && !prog_fall && st_r == ST_IDLE
    |=> prog_act_r && seg_req_r) else $error("program request not answered");
  a_seg_ack_drop: assert property (prog_act_r && seg_req_r && seg_val && !prog_fall
    |=> !seg_req_r) else $error("segment request not dropped");
  a_seg_rerequest: assert property (prog_act_r && !seg_req_r && !seg_val && !prog_fall
    |=> seg_req_r) else $error("next segment not requested");
  a_prog_exit_clr: assert property (prog_fall
    |=> !prog_act_r && !seg_req_r) else $error("programming not left");
  a_wptr_bound: assert property (wr_ptr_r <= SEG_MAX)
    else $error("more than sixteen segments stored");
  a_imm_abort: assert property (busy && imm_rise
    |=> mv_abort && st_r == ST_IDLE) else $error("immediate stop missed");
  a_estop_abort: assert property (busy && estop_rise
    |=> mv_abort) else $error("emergency stop missed");
  a_limit_lock: assert property (moving && limit_cw && !lcw_q_r && !mv_ccw
    |=> lock_cw_r && mv_abort) else $error("clockwise limit not latched");
  a_hold_decel: assert property (st_r == ST_RUN && hold_tog && !abort_go
    |=> mv_decel ##1 !mv_decel) else $error("hold did not decelerate");
  a_dwell_entry: assert property (st_r == ST_RUN && mv_done && !abort_go && !hold_tog
    && !jog_r && !last_seg && !blend_r |=> st_r == ST_DWELL) else $error("no dwell");
  a_lock_holds: assert property (st_r == ST_LOCK
    |=> st_r == ST_LOCK && $stable(ctrl_r)) else $error("saved unit took command");
  a_trig_launch: assert property (st_r == ST_IDLE && armed_r && cmd_any && trig_rise
    && !prog_act_r && !prog_fall |=> st_r == ST_LAUNCH ##1 mv_start || st_r == ST_IDLE)
    else $error("trigger edge did not start");

  c_profile_loaded: cover property (prog_fall && wr_ptr_r >= SEG_MIN);
  c_dwell_done: cover property (st_r == ST_DWELL ##1 st_r == ST_LAUNCH);
  c_triggered_run: cover property (armed_r && trig_rise && st_r == ST_IDLE);
  c_saved: cover property (st_r == ST_SAVE ##1 st_r == ST_LOCK);

endmodule : amseq_top

// ===== bench/amseq_motion_model.sv
// behavioural motion engine and non-volatile store facing the sequencer
module amseq_motion_model #(
  parameter int RUN_CYC = 12,
  parameter int NV_CYC  = 3
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // motion requests
  input  wire logic mv_start,
  input  wire logic mv_cont,
  input  wire logic mv_decel,
  input  wire logic mv_abort,
  output logic      mv_done,
  // store requests
  input  wire logic nv_save,
  output logic      nv_done,
  output logic      nv_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  int run_r;
  int nv_r;

  // a segment runs a fixed time, a jog runs until a stop request ends it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_r   <= 0;
      mv_done <= 1'b0;
    end else begin
      mv_done <= (run_r == 1);
      if (mv_start) begin
        run_r <= mv_cont ? 0 : RUN_CYC;
      end else if (mv_abort || mv_decel) begin
        run_r <= 2;
      end else if (run_r > 0) begin
        run_r <= run_r - 1;
      end
    end
  end

  // store write finishes after a short delay
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nv_r    <= 0;
      nv_done <= 1'b0;
    end else begin
      nv_done <= (nv_r == 1);
      if (nv_save) begin
        nv_r <= NV_CYC;
      end else if (nv_r > 0) begin
        nv_r <= nv_r - 1;
      end
    end
  end

  assign nv_ok = 1'b1;  // saves always succeed here
endmodule : amseq_motion_model

// ===== bench/testbench.sv
// self-checking bench for the move sequencer over its register bus
`include "amseq_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_C = `AMSEQ_OFS_CTRL;
  localparam logic [11:0] A_S = `AMSEQ_OFS_SEG;
  localparam logic [11:0] A_D = `AMSEQ_OFS_DWELL;
  localparam logic [11:0] A_F = `AMSEQ_OFS_CFG;
  localparam logic [11:0] A_T = `AMSEQ_OFS_STATUS;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [2:0]  phys_in = 3'h0;
  logic        limit_cw  = 1'b0;
  logic        limit_ccw = 1'b0;
  logic        pready, pslverr, mv_start, mv_ccw, mv_cont, mv_decel, mv_abort;
  logic        mv_done, nv_save, nv_done, nv_ok, led_green, led_red, err_seen;
  logic [31:0] prdata;
  logic [22:0] mv_dist;
  int          num_errors = 0;
  int          checked    = 0;

  amseq_top #(.TICK_CYCLES(4)) uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .phys_in(phys_in), .limit_cw(limit_cw),
    .limit_ccw(limit_ccw), .mv_start(mv_start), .mv_dist(mv_dist), .mv_ccw(mv_ccw),
    .mv_cont(mv_cont), .mv_decel(mv_decel), .mv_abort(mv_abort),
    .mv_done(mv_done), .nv_save(nv_save), .nv_done(nv_done), .nv_ok(nv_ok),
    .led_green(led_green), .led_red(led_red));

  amseq_motion_model eng (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .mv_start(mv_start), .mv_cont(mv_cont),
    .mv_decel(mv_decel), .mv_abort(mv_abort), .mv_done(mv_done),
    .nv_save(nv_save), .nv_done(nv_done), .nv_ok(nv_ok));

  // free-running system clock
  always #10 sys_clk = ~sys_clk;

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask : check

  // one bus transfer, held until pready, then one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      print_verdict();
    end
    q        = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    @(posedge sys_clk);
    apb(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask : rd

  // wait for a pulse: 0 start, 1 abort, 2 decel, 3 save
  task automatic wt(input int s, output int n);
    logic [3:0] v;
    n = 0;
    v = 4'h0;
    while (v[s] !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      n++;
      v = {nv_save, mv_decel, mv_abort, mv_start};
    end
    if (n >= 300) begin
      num_errors++;
      print_verdict();
    end
  endtask : wt

  // one segment handshake as the host sees it
  task automatic seg(input logic [23:0] t, input logic [31:0] c);
    wr(A_S, {8'h00, t});
    wr(A_C, c | 32'h2);
    rd(A_T, 32'h7, 32'h1);
    wr(A_C, c);
    rd(A_T, 32'h7, 32'h3);
  endtask : seg

  initial begin
    int n;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(A_T, 32'hFFFFFFFF, 32'h0);
    rd(12'h014, 32'hFFFFFFFF, 32'h0);
    check({31'h0, err_seen}, 32'h1);
    wr(A_C, 32'h1);
    rd(A_T, 32'h7, 32'h3);
    seg(24'h000005, 32'h1);
    seg(24'hFFFFFD, 32'h1);
    wr(A_C, 32'h0);
    rd(A_T, 32'h1F0003, 32'h20000);
    $display("program test done");
    wr(A_D, 32'h2);
    wr(A_C, 32'h8);
    wt(0, n);
    check({8'h0, mv_ccw, mv_dist}, 32'h5);
    wt(0, n);
    check({8'h0, mv_ccw, mv_dist}, 32'h800003);
    check({31'h0, n >= 20}, 32'h1);
    repeat (16) @(posedge sys_clk);
    wr(A_C, 32'h0);
    wr(A_C, 32'h38);
    wt(0, n);
    check({8'h0, mv_ccw, mv_dist}, 32'h800005);
    wr(A_C, 32'hB8);
    wt(2, n);
    check({31'h0, n <= 3}, 32'h1);
    repeat (8) @(posedge sys_clk);
    wr(A_C, 32'h0);
    $display("dwell test done");
    wr(A_C, 32'h8);
    wt(0, n);
    wr(A_C, 32'h148);
    wt(1, n);
    check({31'h0, n <= 3}, 32'h1);
    repeat (8) @(posedge sys_clk);
    wr(A_C, 32'h0);
    $display("stop test done");
    wr(A_F, 32'h0);
    wr(A_C, 32'h440);
    rd(A_T, 32'h60, 32'h40);
    phys_in <= 3'h1;
    wt(0, n);
    check({31'h0, mv_cont}, 32'h1);
    phys_in <= 3'h0;
    wr(A_C, 32'h0);
    wt(2, n);
    check({31'h0, n <= 4}, 32'h1);
    repeat (5) @(posedge sys_clk);
    $display("trigger test done");
    wr(A_F, 32'h8);
    wr(A_C, 32'h400);
    wt(0, n);
    phys_in <= 3'h2;
    wt(1, n);
    check({31'h0, n <= 4}, 32'h1);
    phys_in <= 3'h0;
    repeat (5) @(posedge sys_clk);
    wr(A_C, 32'h0);
    $display("estop test done");
    wr(A_C, 32'h400);
    wt(0, n);
    limit_ccw <= 1'b1;
    wt(1, n);
    check({31'h0, n <= 3}, 32'h1);
    limit_ccw <= 1'b0;
    wr(A_C, 32'h0);
    wr(A_C, 32'h400);
    wt(0, n);
    limit_cw <= 1'b1;
    wt(1, n);
    limit_cw <= 1'b0;
    rd(A_T, 32'h18, 32'h8);
    wr(A_C, 32'h0);
    wr(A_C, 32'h400);
    rd(A_T, 32'h3C, 32'hC);
    wr(A_C, 32'h200);
    rd(A_T, 32'h3C, 32'h0);
    $display("limit test done");
    wr(A_C, 32'h5);
    seg(24'h000007, 32'h5);
    seg(24'h000009, 32'h5);
    wr(A_C, 32'h4);
    wt(3, n);
    check({31'h0, n <= 4}, 32'h1);
    repeat (8) @(posedge sys_clk);
    wr(A_C, 32'h400);
    rd(A_T, 32'h1F03A0, 32'h20280);
    $display("save test done");
    print_verdict();
  end
endmodule : testbench
